// >>> rtl/osc_switch_control.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Current source read-only; codes 100-111 reserved.
// - Reset forces current source to fast RC.
// - Completed switch copies requested into current.
// - Fail-safe event forces current source to fast RC.
// - Requested source writable, reset from configuration.
// - Freeze plus monitor config bit locks requested source and switch request.
// - Freeze bit cleared only by reset.
// - PLL lock cleared on start, loss; set on lock.
// - PLL lock reads zero without PLL source.
// - Dither enable resets zero, enables pseudo-random dither.
// - Fail flag set by monitor, software clears it.
// - Valid switch start clears the fail flag.
// - Sequencer on: roll selects base or step.
// - Sequencer off: base tune field only.
// - Writing switch request starts switch to requested.
// - Switch request cleared on reset, done, redundant, fail.
// - Bits 15, 11, 6, 1 read zero.
// - Configuration bits pick source after reset.
module osc_switch_control (
	input  wire logic                 clk,
	input  wire logic                 reset,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire osc_pkg::osc_src_t    cfgInitialSource,
	input  wire logic                 switchMonitorCfgBit1,
	input  wire logic                 pllLockedPin,
	input  wire logic                 failDetectPin,
	input  wire logic                 switchComplete,
	input  wire logic [2:0]           pwmRollSelect,
	output logic                      switchStart,
	output osc_pkg::osc_src_t         currentSourceGroup,
	output osc_pkg::osc_src_t         requestedSourceGroup,
	output logic                      clockSettingsLocked,
	output logic                      ditherEnable,
	output logic                      ditherBit,
	output osc_pkg::osc_tune_t        rcTuneValue
);
	import osc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave state.

	logic        awHeld;
	logic [7:0]  awAddr;
	logic        wHeld;
	logic [15:0] wData;
	logic [1:0]  wStrb;
	logic        bValid;
	logic [1:0]  bResp;
	logic        rValid;
	logic [31:0] rData;
	logic [1:0]  rResp;
	logic        next_awHeld;
	logic [7:0]  next_awAddr;
	logic        next_wHeld;
	logic [15:0] next_wData;
	logic [1:0]  next_wStrb;
	logic        next_bValid;
	logic [1:0]  next_bResp;
	logic        next_rValid;
	logic [31:0] next_rData;
	logic [1:0]  next_rResp;

	////////////////////////////////////////////////////////////////////////////////
	// Control state.

	osc_sw_state_e state;
	osc_sw_state_e next_state;
	osc_src_t      currentSource;
	osc_src_t      next_current;
	osc_src_t      requestedSource;
	osc_src_t      next_requested;
	logic          switchRequest;
	logic          next_swReq;
	logic          bootPending;
	logic          next_boot;
	logic          clockFreeze;
	logic          next_freeze;
	logic          lockStatus;
	logic          next_lock;
	logic          clockFail;
	logic          next_fail;
	logic          tuneSeqEnable;
	logic          next_tseq;
	logic          ditherOn;
	logic          next_dither;
	osc_tune_t     baseTune;
	osc_tune_t     next_base;
	osc_steps_t    tuneStep;
	osc_steps_t    next_steps;
	logic [15:0]   lfsr;
	logic [15:0]   next_lfsr;
	logic          pllMeta;
	logic          pllSync;
	logic          pllSyncD;
	logic          failMeta;
	logic          failSync;
	logic          failSyncD;
	logic          pllRise;
	logic          failRise;
	logic          frozen;
	logic          doWrite;
	logic          wrCtrl;
	logic          wrTune;
	logic          wrTune2;
	logic [15:0]   ctrlRead;

	osc_tune_if tuneBus ();

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: one write and one read in flight, address and data in either order.

	assign s_axi_awready = !awHeld && !bValid;
	assign s_axi_wready  = !wHeld && !bValid;
	assign s_axi_arready = !rValid;
	assign s_axi_bvalid  = bValid;
	assign s_axi_bresp   = bResp;
	assign s_axi_rvalid  = rValid;
	assign s_axi_rdata   = rData;
	assign s_axi_rresp   = rResp;

	assign doWrite = awHeld && wHeld && !bValid;
	assign wrCtrl  = doWrite && awAddr[7:2] == OFS_CTRL[7:2];
	assign wrTune  = doWrite && awAddr[7:2] == OFS_TUNE[7:2];
	assign wrTune2 = doWrite && awAddr[7:2] == OFS_TUNE2[7:2];

	assign ctrlRead = {1'b0, currentSource, 1'b0, requestedSource, clockFreeze, 1'b0,
		lockStatus & currentSource[0], ditherOn, clockFail, tuneSeqEnable, 1'b0, switchRequest};

	always_comb
	begin
		next_awHeld = awHeld;
		next_awAddr = awAddr;
		next_wHeld  = wHeld;
		next_wData  = wData;
		next_wStrb  = wStrb;
		next_bValid = bValid;
		next_bResp  = bResp;
		next_rValid = rValid;
		next_rData  = rData;
		next_rResp  = rResp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_awHeld = 1'b1;
			next_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata[15:0];
			next_wStrb = s_axi_wstrb[1:0];
		end
		if (doWrite)
		begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bValid = 1'b1;
			next_bResp  = (wrCtrl || wrTune || wrTune2) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bValid && s_axi_bready)
			next_bValid = 1'b0;
		if (rValid && s_axi_rready)
			next_rValid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rValid = 1'b1;
			next_rResp  = RESP_OKAY;
			case (s_axi_araddr[7:2])
				OFS_CTRL[7:2]:  next_rData = {16'h0000, ctrlRead & CTRL_MASK};
				OFS_TUNE[7:2]:  next_rData = {16'h0000, tuneStep[2], tuneStep[1], tuneStep[0], baseTune};
				OFS_TUNE2[7:2]: next_rData = {16'h0000, tuneStep[6], tuneStep[5], tuneStep[4], tuneStep[3]};
				default:
				begin
					next_rData = 32'h00000000;
					next_rResp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			awHeld <= 1'b0;
			awAddr <= 8'h00;
			wHeld  <= 1'b0;
			wData  <= 16'h0000;
			wStrb  <= 2'h0;
			bValid <= 1'b0;
			bResp  <= RESP_OKAY;
			rValid <= 1'b0;
			rData  <= 32'h00000000;
			rResp  <= RESP_OKAY;
		end
		else
		begin
			awHeld <= next_awHeld;
			awAddr <= next_awAddr;
			wHeld  <= next_wHeld;
			wData  <= next_wData;
			wStrb  <= next_wStrb;
			bValid <= next_bValid;
			bResp  <= next_bResp;
			rValid <= next_rValid;
			rData  <= next_rData;
			rResp  <= next_rResp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator control. Later assignments win, so a fail event overrides a clear and a start's next state; switchStart and the lock clear still take effect.

	assign pllRise  = pllSync && !pllSyncD;
	assign failRise = failSync && !failSyncD;
	assign frozen   = clockFreeze && switchMonitorCfgBit1;

	always_comb
	begin
		next_state     = state;
		next_current   = currentSource;
		next_requested = requestedSource;
		next_swReq     = switchRequest;
		next_boot      = bootPending;
		next_freeze    = clockFreeze;
		next_lock      = lockStatus;
		next_fail      = clockFail;
		next_tseq      = tuneSeqEnable;
		next_dither    = ditherOn;
		next_base      = baseTune;
		next_steps     = tuneStep;
		switchStart    = 1'b0;
		if (wrCtrl && wStrb[1] && !frozen)
			next_requested = wData[BIT_REQ_LSB +: 3];
		if (wrCtrl && wStrb[0])
		begin
			if (wData[BIT_FREEZE])
				next_freeze = 1'b1;
			next_dither = wData[BIT_DITHER];
			next_tseq   = wData[BIT_TSEQ];
			if (!wData[BIT_FAIL])
				next_fail = 1'b0;
			if (wData[BIT_SWREQ] && !frozen)
				next_swReq = 1'b1;
		end
		if (wrTune && wStrb[0])
			{next_steps[0], next_base} = wData[7:0];
		if (wrTune && wStrb[1])
			{next_steps[2], next_steps[1]} = wData[15:8];
		if (wrTune2 && wStrb[0])
			{next_steps[4], next_steps[3]} = wData[7:0];
		if (wrTune2 && wStrb[1])
			{next_steps[6], next_steps[5]} = wData[15:8];
		if (!pllSync)
			next_lock = 1'b0;
		else if (pllRise)
			next_lock = 1'b1;
		case (state)
			OSC_SW_IDLE:
			begin
				if ((switchRequest || bootPending) && !reset)
				begin
					next_boot = 1'b0;
					if (requestedSource == currentSource || requestedSource > SRC_MAX_VALID)
					begin
						next_swReq = 1'b0;
					end
					else
					begin
						switchStart = 1'b1;
						next_state  = OSC_SW_WAIT;
						next_lock   = 1'b0;
						next_fail   = 1'b0;
					end
				end
			end
			OSC_SW_WAIT:
			begin
				if (switchComplete)
				begin
					next_current = requestedSource;
					next_swReq   = 1'b0;
					next_state   = OSC_SW_IDLE;
				end
			end
			default:
			begin
				next_state = OSC_SW_IDLE;
			end
		endcase
		if (failRise)
		begin
			next_current = SRC_FRC;
			next_fail    = 1'b1;
			next_swReq   = 1'b0;
			next_boot    = 1'b0;
			next_state   = OSC_SW_IDLE;
		end
	end

	// Dither source: a Galois LFSR that advances only while dithering is on.
	always_comb
	begin
		next_lfsr = lfsr;
		if (ditherOn)
			next_lfsr = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? LFSR_TAPS : 16'h0000);
	end

	// The requested field is loaded from the configuration straps on reset; the first
	// switch after reset then moves the clock to that source.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state           <= OSC_SW_IDLE;
			currentSource   <= SRC_FRC;
			requestedSource <= cfgInitialSource;
			switchRequest   <= 1'b0;
			bootPending     <= 1'b1;
			clockFreeze     <= 1'b0;
			lockStatus      <= 1'b0;
			clockFail       <= 1'b0;
			tuneSeqEnable   <= 1'b0;
			ditherOn        <= 1'b0;
			baseTune        <= TUNE_RESET;
			tuneStep        <= '0;
			lfsr            <= LFSR_SEED;
			pllMeta         <= 1'b0;
			pllSync         <= 1'b0;
			pllSyncD        <= 1'b0;
			failMeta        <= 1'b0;
			failSync        <= 1'b0;
			failSyncD       <= 1'b0;
		end
		else
		begin
			state           <= next_state;
			currentSource   <= next_current;
			requestedSource <= next_requested;
			switchRequest   <= next_swReq;
			bootPending     <= next_boot;
			clockFreeze     <= next_freeze;
			lockStatus      <= next_lock;
			clockFail       <= next_fail;
			tuneSeqEnable   <= next_tseq;
			ditherOn        <= next_dither;
			baseTune        <= next_base;
			tuneStep        <= next_steps;
			lfsr            <= next_lfsr;
			pllMeta         <= pllLockedPin;
			pllSync         <= pllMeta;
			pllSyncD        <= pllSync;
			failMeta        <= failDetectPin;
			failSync        <= failMeta;
			failSyncD       <= failSync;
		end
	end

	assign currentSourceGroup   = currentSource;
	assign requestedSourceGroup = requestedSource;
	assign clockSettingsLocked  = frozen;
	assign ditherEnable         = ditherOn;
	assign ditherBit            = lfsr[0];

	////////////////////////////////////////////////////////////////////////////////
	// Tune selection.

	assign tuneBus.baseTune   = baseTune;
	assign tuneBus.tuneStep   = tuneStep;
	assign tuneBus.seqEnable  = tuneSeqEnable;
	assign tuneBus.rollSelect = pwmRollSelect;
	assign rcTuneValue        = tuneBus.tuneValue;

	osc_tune_select u_tune (
		.clk   (clk),
		.reset (reset),
		.tune  (tuneBus.sel)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_redundant_req;
		state == OSC_SW_IDLE && switchRequest && requestedSource == currentSource && !failRise;
	endsequence

	sequence s_redundant_done;
		!switchRequest && $stable(currentSource) && state == OSC_SW_IDLE;
	endsequence

	sequence s_switch_done;
		state == OSC_SW_WAIT && switchComplete && !failRise;
	endsequence

	a_cur_after_reset: assert property ($past(reset) |-> currentSource == SRC_FRC)
		else $error("Current source not fast RC after reset.");
	a_cur_code_valid: assert property (currentSource <= SRC_MAX_VALID)
		else $error("Current source holds a reserved code.");
	a_cur_load_done: assert property (s_switch_done |=> currentSource == $past(requestedSource) && !switchRequest)
		else $error("Completed switch did not load current source.");
	a_fail_to_frc: assert property (failRise |=> currentSource == SRC_FRC && clockFail && !switchRequest)
		else $error("Fail event did not force fast RC.");
	a_freeze_sticky: assert property (clockFreeze |=> clockFreeze)
		else $error("Freeze bit cleared without reset.");
	a_frozen_hold: assert property (frozen |=> $stable(requestedSource) && !$rose(switchRequest))
		else $error("Write accepted while settings frozen.");
	a_lock_read_zero: assert property (!currentSource[0] |-> !ctrlRead[BIT_LOCK])
		else $error("PLL lock visible without PLL source.");
	a_start_clears: assert property (switchStart && !failRise |=> !lockStatus && !clockFail)
		else $error("Switch start did not clear lock and fail flags.");
	a_redundant_req: assert property (s_redundant_req |=> s_redundant_done)
		else $error("Redundant switch mishandled.");
	a_unimpl_zero: assert property (rValid && $past(s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00)
		&& $rose(rValid) |-> (rData[15:0] & ~CTRL_MASK) == 16'h0000)
		else $error("Unimplemented control bit read as one.");
	a_bresp_hold: assert property (bValid && !s_axi_bready |=> bValid && $stable(bResp))
		else $error("Write response dropped before taken.");
endmodule : osc_switch_control

// >>> common/osc_pkg.sv
package osc_pkg;
	typedef logic [2:0]      osc_src_t;
	typedef logic [3:0]      osc_tune_t;
	typedef logic [6:0][3:0] osc_steps_t;
	typedef enum logic [1:0]
	{
		OSC_SW_IDLE = 2'b00,
		OSC_SW_WAIT = 2'b01
	} osc_sw_state_e;

	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_TUNE      = 8'h04;
	localparam logic [7:0]  OFS_TUNE2     = 8'h08;
	localparam int          BIT_CUR_LSB   = 12;
	localparam int          BIT_REQ_LSB   = 8;
	localparam int          BIT_FREEZE    = 7;
	localparam int          BIT_LOCK      = 5;
	localparam int          BIT_DITHER    = 4;
	localparam int          BIT_FAIL      = 3;
	localparam int          BIT_TSEQ      = 2;
	localparam int          BIT_SWREQ     = 0;
	localparam logic [15:0] CTRL_MASK     = 16'h77BD;
	localparam osc_src_t    SRC_FRC       = 3'h0;
	localparam osc_src_t    SRC_FRC_PLL   = 3'h1;
	localparam osc_src_t    SRC_PRI       = 3'h2;
	localparam osc_src_t    SRC_PRI_PLL   = 3'h3;
	localparam osc_src_t    SRC_MAX_VALID = 3'h3;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [15:0] LFSR_SEED     = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS     = 16'hB400;
	localparam osc_tune_t   TUNE_RESET    = 4'h0;
endpackage : osc_pkg

// >>> common/osc_tune_if.sv
`timescale 1ns/1ps
interface osc_tune_if;
	import osc_pkg::*;
	osc_tune_t  baseTune;
	osc_steps_t tuneStep;
	logic       seqEnable;
	logic [2:0] rollSelect;
	osc_tune_t  tuneValue;
	modport ctrl (output baseTune, output tuneStep, output seqEnable, output rollSelect, input tuneValue);
	modport sel (input baseTune, input tuneStep, input seqEnable, input rollSelect, output tuneValue);
endinterface : osc_tune_if

// >>> rtl/osc_tune_select.sv
`timescale 1ns/1ps
module osc_tune_select (
	input wire logic clk,
	input wire logic reset,
	osc_tune_if.sel  tune
);
	import osc_pkg::*;

	osc_tune_t tuneValue;
	osc_tune_t next_tuneValue;

	always_comb
	begin
		next_tuneValue = tune.baseTune;
		if (tune.seqEnable && tune.rollSelect != 3'h0)
		begin
			next_tuneValue = tune.tuneStep[3'(tune.rollSelect - 3'h1)];
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			tuneValue <= TUNE_RESET;
		else
			tuneValue <= next_tuneValue;
	end

	assign tune.tuneValue = tuneValue;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_tune_base_only: assert property (!tune.seqEnable |=> tuneValue == $past(tune.baseTune))
		else $error("Tune value not taken from base field.");
	a_tune_step_pick: assert property (tune.seqEnable && tune.rollSelect == 3'h7
		|=> tuneValue == $past(tune.tuneStep[6]))
		else $error("Tune value not taken from step seven.");
endmodule : osc_tune_select

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import osc_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic        s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	osc_src_t    cfgInitialSource = SRC_FRC;
	logic        switchMonitorCfgBit1 = 1'b0;
	logic        pllLockedPin = 1'b0;
	logic        failDetectPin = 1'b0;
	logic        switchComplete = 1'b0;
	logic [2:0]  pwmRollSelect = 3'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        switchStart, clockSettingsLocked, ditherEnable, ditherBit;
	osc_src_t    currentSourceGroup, requestedSourceGroup;
	osc_tune_t   rcTuneValue;
	int          errTotal = 0;
	int          numChecks = 0;
	int          startCount = 0;

	always #4 clk = ~clk;

	osc_switch_control dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .cfgInitialSource, .switchMonitorCfgBit1, .pllLockedPin, .failDetectPin,
		.switchComplete, .pwmRollSelect, .switchStart, .currentSourceGroup, .requestedSourceGroup,
		.clockSettingsLocked, .ditherEnable, .ditherBit, .rcTuneValue);

	// The start pulse lasts one cycle, so it is counted here rather than polled by the scenarios.
	always @(posedge clk)
		if (!reset && switchStart === 1'b1)
			startCount <= startCount + 1;

	////////////////////////////////////////
	task automatic complete_run();
		if (errTotal == 0 && numChecks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp)
		begin
			errTotal++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	function automatic logic [31:0] ctl(input osc_src_t cur, input osc_src_t req, input logic [7:0] low);
		return {16'h0000, 1'b0, cur, 1'b0, req, low};
	endfunction : ctl

	task automatic do_reset();
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset

	task automatic bus_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wstrb <= 4'h3;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// No cycle budget here: only the watchdog ends a stalled handshake.
		do
		begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : bus_write

	task automatic bus_read(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata, e);
		check({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : bus_read

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus_write(a, d, RESP_OKAY);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus_read(a, e, RESP_OKAY);
	endtask : rd

	task automatic wait_start(input int base);
		int n;
		for (n = 0; n < 20 && startCount == base; n++)
			@(posedge clk);
		check(startCount - base, 1);
	endtask : wait_start

	task automatic finish_switch();
		switchComplete <= 1'b1;
		@(posedge clk);
		switchComplete <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : finish_switch

	////////////////////////////////////////
	task automatic t_reset_values();
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_FRC, 8'h00));
		rd(OFS_TUNE, 32'h0);
		check({31'h0, clockSettingsLocked}, 32'h0);
	endtask : t_reset_values

	task automatic t_switch();
		int base;
		base = startCount;
		wr(OFS_CTRL, 16'h0301);
		wait_start(base);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_PRI_PLL, 8'h01));
		finish_switch();
		rd(OFS_CTRL, ctl(SRC_PRI_PLL, SRC_PRI_PLL, 8'h00));
		check({29'h0, currentSourceGroup}, {29'h0, SRC_PRI_PLL});
		check({29'h0, requestedSourceGroup}, {29'h0, SRC_PRI_PLL});
		pllLockedPin <= 1'b1;
		repeat (6) @(posedge clk);
		rd(OFS_CTRL, ctl(SRC_PRI_PLL, SRC_PRI_PLL, 8'h20));
		pllLockedPin <= 1'b0;
		repeat (6) @(posedge clk);
		rd(OFS_CTRL, ctl(SRC_PRI_PLL, SRC_PRI_PLL, 8'h00));
	endtask : t_switch

	task automatic t_redundant();
		int base;
		base = startCount;
		wr(OFS_CTRL, 16'h0301);
		repeat (8) @(posedge clk);
		check(startCount - base, 0);
		rd(OFS_CTRL, ctl(SRC_PRI_PLL, SRC_PRI_PLL, 8'h00));
	endtask : t_redundant

	task automatic t_fail();
		int base;
		pllLockedPin <= 1'b1;
		failDetectPin <= 1'b1;
		repeat (8) @(posedge clk);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_PRI_PLL, 8'h08));
		wr(OFS_CTRL, 16'h0300);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_PRI_PLL, 8'h00));
		failDetectPin <= 1'b0;
		repeat (4) @(posedge clk);
		failDetectPin <= 1'b1;
		repeat (8) @(posedge clk);
		base = startCount;
		wr(OFS_CTRL, 16'h0209);
		wait_start(base);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_PRI, 8'h01));
		finish_switch();
		rd(OFS_CTRL, ctl(SRC_PRI, SRC_PRI, 8'h00));
		failDetectPin <= 1'b0;
		pllLockedPin <= 1'b0;
	endtask : t_fail

	task automatic t_freeze();
		int base;
		switchMonitorCfgBit1 <= 1'b1;
		wr(OFS_CTRL, 16'h0280);
		check({31'h0, clockSettingsLocked}, 32'h1);
		base = startCount;
		wr(OFS_CTRL, 16'h0101);
		repeat (6) @(posedge clk);
		check(startCount - base, 0);
		rd(OFS_CTRL, ctl(SRC_PRI, SRC_PRI, 8'h80));
		switchMonitorCfgBit1 <= 1'b0;
		wr(OFS_CTRL, 16'h0100);
		check({31'h0, clockSettingsLocked}, 32'h0);
		rd(OFS_CTRL, ctl(SRC_PRI, SRC_FRC_PLL, 8'h80));
		do_reset();
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_FRC, 8'h00));
	endtask : t_freeze

	task automatic t_dither();
		int ones;
		wr(OFS_CTRL, 16'h0010);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_FRC, 8'h10));
		ones = 0;
		repeat (16)
		begin
			@(posedge clk);
			ones += (ditherBit === 1'b1);
		end
		// A stuck dither output would give all zeros or all ones over sixteen steps.
		check({31'h0, ones > 0 && ones < 16}, 32'h1);
		wr(OFS_CTRL, 16'h0000);
		check({31'h0, ditherEnable}, 32'h0);
	endtask : t_dither

	task automatic t_tune();
		int r;
		wr(OFS_TUNE, 16'h4321);
		wr(OFS_TUNE2, 16'h8765);
		rd(OFS_TUNE2, 32'h8765);
		for (r = 0; r < 8; r++)
		begin
			pwmRollSelect <= r[2:0];
			repeat (3) @(posedge clk);
			check({28'h0, rcTuneValue}, 32'h1);
		end
		wr(OFS_CTRL, 16'h0004);
		for (r = 0; r < 8; r++)
		begin
			pwmRollSelect <= r[2:0];
			repeat (3) @(posedge clk);
			check({28'h0, rcTuneValue}, r + 1);
		end
	endtask : t_tune

	task automatic t_bus_errors();
		int base;
		bus_write(8'h0C, 16'hFFFF, RESP_SLVERR);
		bus_read(8'h0C, 32'h0, RESP_SLVERR);
		base = startCount;
		wr(OFS_CTRL, 16'h0501);
		repeat (4) @(posedge clk);
		check(startCount - base, 0);
		rd(OFS_CTRL, ctl(SRC_FRC, 3'h5, 8'h00));
		wr(OFS_CTRL, 16'hF842);
		rd(OFS_CTRL, ctl(SRC_FRC, SRC_FRC, 8'h00));
	endtask : t_bus_errors

	task automatic t_boot();
		int base;
		cfgInitialSource <= SRC_PRI;
		base = startCount;
		do_reset();
		wait_start(base);
		finish_switch();
		rd(OFS_CTRL, ctl(SRC_PRI, SRC_PRI, 8'h00));
	endtask : t_boot

	////////////////////////////////////////
	initial
	begin
		do_reset();
		t_reset_values();
		t_switch();
		t_redundant();
		t_fail();
		t_freeze();
		t_dither();
		t_tune();
		t_bus_errors();
		t_boot();
		complete_run();
	end

	// The scenarios need a few hundred cycles; this bound only catches a stalled handshake.
	initial
	begin
		repeat (20000) @(posedge clk);
		errTotal++;
		complete_run();
	end
endmodule : testbench
